// [logic/saved_state_ram.sv]
`default_nettype none
module saved_state_ram (
    // clock
    input  wire logic                                 clk,
    // write port
    input  wire logic                                 wr_en,
    input  wire trap_stack_pkg::level_t               wr_idx,
    input  wire logic [trap_stack_pkg::SS_W-1:0]      wr_data,
    // read port
    input  wire trap_stack_pkg::level_t               rd_idx,
    output logic [trap_stack_pkg::SS_W-1:0]           rd_data
);
    // no reset: contents after power-on are left undefined
    logic [trap_stack_pkg::SS_W-1:0] mem [1:trap_stack_pkg::MAX_TRAP_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_comb begin
        rd_data = '0;
        if (rd_idx != trap_stack_pkg::LEVEL_ZERO &&
            rd_idx <= trap_stack_pkg::LEVEL_MAX) begin
            rd_data = mem[rd_idx];
        end
    end
endmodule
`default_nettype wire

// [logic/trap_cause_ram.sv]
`default_nettype none
module trap_cause_ram (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    // write port
    input  wire logic                                 wr_en,
    input  wire trap_stack_pkg::level_t               wr_idx,
    input  wire logic [trap_stack_pkg::CAUSE_W-1:0]   wr_data,
    // read port
    input  wire trap_stack_pkg::level_t               rd_idx,
    output logic [trap_stack_pkg::CAUSE_W-1:0]        rd_data
);
    // lower entries carry no reset; only the deepest one is loaded
    logic [trap_stack_pkg::CAUSE_W-1:0]
        mem [1:trap_stack_pkg::MAX_TRAP_DEPTH-1];
    logic [trap_stack_pkg::CAUSE_W-1:0] top_entry;

    always_ff @(posedge clk) begin
        if (wr_en && wr_idx != trap_stack_pkg::LEVEL_MAX) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            top_entry <= trap_stack_pkg::CAUSE_POR;
        end else if (wr_en && wr_idx == trap_stack_pkg::LEVEL_MAX) begin
            top_entry <= wr_data;
        end
    end

    always_comb begin
        rd_data = '0;
        if (rd_idx == trap_stack_pkg::LEVEL_MAX) begin
            rd_data = top_entry;
        end else if (rd_idx != trap_stack_pkg::LEVEL_ZERO &&
                     rd_idx < trap_stack_pkg::LEVEL_MAX) begin
            rd_data = mem[rd_idx];
        end
    end
endmodule
`default_nettype wire

// [logic/trap_level_state_stack.sv]
// Contract
// RULE1: one saved-state entry per level, selected by level
// RULE2: saved-state access at level zero is bad opcode
// RULE3: trap captures bank, codes, space, pointer, control
// RULE4: fixed field positions; two gaps are read-only
// RULE5: control word saved is thirteen bits
// RULE6: trap writes n+1; return and access use n
// RULE7: saved-state entries need no reset value
// RULE8: entries above current level are undefined
// RULE9: cause entry holds type code of entry trap
// RULE10: cause stack per level; level zero is bad opcode
// RULE11: reset loads deepest cause entry with one
// RULE12: trap writes cause n+1; access uses n
// RULE13: vector base supplies address bits 63 to 15
// RULE14: vector base low fifteen bits read zero
// RULE15: spill or fill inserts handler select bits
// RULE16: refused level-zero write changes no entry
`default_nettype none
module trap_level_state_stack (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    // current trap level
    input  wire trap_stack_pkg::level_t               trap_level,
    // trap entry
    input  wire logic                                 trap_take,
    input  wire logic [trap_stack_pkg::CAUSE_W-1:0]   trap_cause_code,
    input  wire logic                                 trap_spill_fill,
    input  wire logic [trap_stack_pkg::SEL_W-1:0]     window_handler_select,
    input  wire logic [trap_stack_pkg::SS_GL_W-1:0]   bank_select_level,
    input  wire logic [trap_stack_pkg::SS_CCR_W-1:0]  cur_ccr,
    input  wire logic [trap_stack_pkg::SS_ASI_W-1:0]  cur_asi,
    input  wire logic [trap_stack_pkg::SS_PCW_W-1:0]  cur_pcw,
    input  wire logic [trap_stack_pkg::SS_CWP_W-1:0]  cur_cwp,
    // trap return
    input  wire logic                                 return_take,
    output logic                                      rest_valid,
    output logic [trap_stack_pkg::SS_GL_W-1:0]        rest_gl,
    output logic [trap_stack_pkg::SS_CCR_W-1:0]       rest_ccr,
    output logic [trap_stack_pkg::SS_ASI_W-1:0]       rest_asi,
    output logic [trap_stack_pkg::SS_PCW_W-1:0]       rest_pcw,
    output logic [trap_stack_pkg::SS_CWP_W-1:0]       rest_cwp,
    // privileged register access
    input  wire logic                                 preg_valid,
    input  wire logic                                 preg_write,
    input  wire trap_stack_pkg::priv_reg_e            preg_sel,
    input  wire logic [trap_stack_pkg::VB_W-1:0]      preg_wdata,
    output logic                                      preg_done,
    output logic [trap_stack_pkg::VB_W-1:0]           preg_rdata,
    output logic                                      bad_opcode,
    // vector base for trap address generation
    output logic [trap_stack_pkg::VB_W-1:0]           trap_vector_base
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic level_in_stack(input trap_stack_pkg::level_t l);
        level_in_stack = (l != trap_stack_pkg::LEVEL_ZERO) &&
                         (l <= trap_stack_pkg::LEVEL_MAX);
    endfunction

    function automatic logic stacked_reg(input trap_stack_pkg::priv_reg_e s);
        stacked_reg = (s == trap_stack_pkg::REG_SAVED_STATE) ||
                      (s == trap_stack_pkg::REG_TRAP_CAUSE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode

    trap_stack_pkg::level_t                  level_up;
    logic                                    trap_fire;
    logic                                    return_fire;
    logic                                    access_fire;
    logic                                    access_refused;
    logic [trap_stack_pkg::SS_W-1:0]         captured_state;
    logic [trap_stack_pkg::CAUSE_W-1:0]      captured_cause;
    logic                                    ss_wr_en;
    trap_stack_pkg::level_t                  ss_wr_idx;
    logic [trap_stack_pkg::SS_W-1:0]         ss_wr_data;
    logic [trap_stack_pkg::SS_W-1:0]         ss_rd_data;
    logic                                    cause_wr_en;
    trap_stack_pkg::level_t                  cause_wr_idx;
    logic [trap_stack_pkg::CAUSE_W-1:0]      cause_wr_data;
    logic [trap_stack_pkg::CAUSE_W-1:0]      cause_rd_data;

    assign level_up = trap_level + trap_stack_pkg::LEVEL_ONE;

    // a trap at the deepest level has nowhere to go and is dropped here
    assign trap_fire = trap_take && trap_level < trap_stack_pkg::LEVEL_MAX;

    // trap wins the cycle; the sequencer is not expected to overlap them
    assign return_fire = return_take && !trap_take &&
                         level_in_stack(trap_level);

    assign access_fire = preg_valid && !trap_take && !return_take;

    assign access_refused = access_fire && stacked_reg(preg_sel) &&
                            !level_in_stack(trap_level); // [RULE2] [RULE10]

    always_comb begin
        captured_state = '0;
        captured_state[trap_stack_pkg::SS_GL_LO +: trap_stack_pkg::SS_GL_W]
            = bank_select_level; // [RULE3] [RULE4]
        captured_state[trap_stack_pkg::SS_CCR_LO +: trap_stack_pkg::SS_CCR_W]
            = cur_ccr; // [RULE3] [RULE4]
        captured_state[trap_stack_pkg::SS_ASI_LO +: trap_stack_pkg::SS_ASI_W]
            = cur_asi; // [RULE3] [RULE4]
        captured_state[trap_stack_pkg::SS_PCW_LO +: trap_stack_pkg::SS_PCW_W]
            = cur_pcw; // [RULE3] [RULE5]
        captured_state[trap_stack_pkg::SS_CWP_LO +: trap_stack_pkg::SS_CWP_W]
            = cur_cwp; // [RULE3] [RULE4]
    end

    always_comb begin
        captured_cause = trap_cause_code; // [RULE9]
        if (trap_spill_fill) begin
            captured_cause[trap_stack_pkg::CAUSE_SEL_LO +:
                           trap_stack_pkg::SEL_W]
                = window_handler_select; // [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stack write arbitration

    always_comb begin
        ss_wr_en      = 1'b0;
        ss_wr_idx     = trap_level;
        ss_wr_data    = '0;
        cause_wr_en   = 1'b0;
        cause_wr_idx  = trap_level;
        cause_wr_data = preg_wdata[trap_stack_pkg::CAUSE_W-1:0];
        if (trap_fire) begin
            ss_wr_en      = 1'b1; // [RULE6]
            ss_wr_idx     = level_up;
            ss_wr_data    = captured_state;
            cause_wr_en   = 1'b1; // [RULE12]
            cause_wr_idx  = level_up;
            cause_wr_data = captured_cause;
        end else if (access_fire && preg_write && !access_refused) begin
            // refused accesses fall through and touch nothing [RULE16]
            ss_wr_en    = (preg_sel == trap_stack_pkg::REG_SAVED_STATE);
            ss_wr_data  = preg_wdata[trap_stack_pkg::SS_W-1:0] &
                          trap_stack_pkg::SS_WRITE_MASK; // [RULE4]
            cause_wr_en = (preg_sel == trap_stack_pkg::REG_TRAP_CAUSE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage, read at the current level

    // no reset on saved-state entries [RULE7] [RULE8]
    saved_state_ram u_saved_state (
        .clk     (clk),
        .wr_en   (ss_wr_en),
        .wr_idx  (ss_wr_idx),
        .wr_data (ss_wr_data),
        .rd_idx  (trap_level), // [RULE1] [RULE6]
        .rd_data (ss_rd_data)
    );

    // deepest entry comes out of reset at the power-on code [RULE11]
    trap_cause_ram u_trap_cause (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (cause_wr_en),
        .wr_idx  (cause_wr_idx),
        .wr_data (cause_wr_data),
        .rd_idx  (trap_level), // [RULE10] [RULE12]
        .rd_data (cause_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    logic                                    next_rest_valid;
    logic [trap_stack_pkg::SS_W-1:0]         next_rest_word;
    logic                                    next_preg_done;
    logic [trap_stack_pkg::VB_W-1:0]         next_preg_rdata;
    logic                                    next_bad_opcode;
    logic [trap_stack_pkg::VB_W-1:0]         next_vector_base;
    logic [trap_stack_pkg::SS_W-1:0]         rest_word;

    always_comb begin
        next_rest_valid  = return_fire;
        next_rest_word   = return_fire ? ss_rd_data : rest_word; // [RULE6]
        next_preg_done   = access_fire && !access_refused;
        next_preg_rdata  = '0;
        next_bad_opcode  = access_refused; // [RULE2] [RULE10]
        next_vector_base = trap_vector_base;
        if (access_fire && !access_refused) begin
            unique case (preg_sel)
                trap_stack_pkg::REG_SAVED_STATE: begin
                    next_preg_rdata[trap_stack_pkg::SS_W-1:0] = ss_rd_data;
                end
                trap_stack_pkg::REG_TRAP_CAUSE: begin
                    next_preg_rdata[trap_stack_pkg::CAUSE_W-1:0] =
                        cause_rd_data;
                end
                trap_stack_pkg::REG_VECTOR_BASE: begin
                    next_preg_rdata = trap_vector_base;
                    if (preg_write) begin
                        next_vector_base = preg_wdata &
                            trap_stack_pkg::VB_WRITE_MASK; // [RULE13] [RULE14]
                    end
                end
                default: begin
                    // unused selector code: completes, reads zero
                    next_preg_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rest_valid       <= 1'b0;
            rest_word        <= '0;
            preg_done        <= 1'b0;
            preg_rdata       <= '0;
            bad_opcode       <= 1'b0;
            trap_vector_base <= trap_stack_pkg::VB_RESET;
        end else begin
            rest_valid       <= next_rest_valid;
            rest_word        <= next_rest_word;
            preg_done        <= next_preg_done;
            preg_rdata       <= next_preg_rdata;
            bad_opcode       <= next_bad_opcode;
            trap_vector_base <= next_vector_base;
        end
    end

    assign rest_gl  = rest_word[trap_stack_pkg::SS_GL_LO +:
                                trap_stack_pkg::SS_GL_W];
    assign rest_ccr = rest_word[trap_stack_pkg::SS_CCR_LO +:
                                trap_stack_pkg::SS_CCR_W];
    assign rest_asi = rest_word[trap_stack_pkg::SS_ASI_LO +:
                                trap_stack_pkg::SS_ASI_W];
    assign rest_pcw = rest_word[trap_stack_pkg::SS_PCW_LO +:
                                trap_stack_pkg::SS_PCW_W];
    assign rest_cwp = rest_word[trap_stack_pkg::SS_CWP_LO +:
                                trap_stack_pkg::SS_CWP_W];

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_refuse_level_zero;
        @(posedge clk) disable iff (!reset_n)
        access_fire && trap_level == 3'h0 && stacked_reg(preg_sel)
            |=> bad_opcode && !preg_done;
    endproperty
    a_refuse_level_zero: assert property (p_refuse_level_zero) // [RULE2]
        else $error("level-zero stacked access not refused");

    property p_refused_write_inert;
        @(posedge clk) disable iff (!reset_n)
        access_refused |-> !ss_wr_en && !cause_wr_en;
    endproperty
    a_refused_write_inert: assert property (p_refused_write_inert) // [RULE16]
        else $error("refused access wrote a stack entry");

    property p_trap_writes_next;
        @(posedge clk) disable iff (!reset_n)
        trap_fire |-> ss_wr_en && ss_wr_idx == trap_level + 3'h1 &&
                      cause_wr_en && cause_wr_idx == trap_level + 3'h1;
    endproperty
    a_trap_writes_next: assert property (p_trap_writes_next) // [RULE6]
        else $error("trap did not write the next level");

    property p_capture_fields;
        @(posedge clk) disable iff (!reset_n)
        trap_fire |-> ss_wr_data[20:8] == cur_pcw &&
                      ss_wr_data[42:40] == bank_select_level &&
                      ss_wr_data[4:0] == cur_cwp;
    endproperty
    a_capture_fields: assert property (p_capture_fields) // [RULE5]
        else $error("captured state fields misplaced");

    property p_readonly_gaps;
        @(posedge clk) disable iff (!reset_n)
        ss_wr_en |-> ss_wr_data[23:21] == 3'h0 && ss_wr_data[7:5] == 3'h0;
    endproperty
    a_readonly_gaps: assert property (p_readonly_gaps) // [RULE4]
        else $error("read-only gap bits written");

    property p_handler_select;
        @(posedge clk) disable iff (!reset_n)
        trap_fire && trap_spill_fill
            |-> cause_wr_data[4:2] == window_handler_select &&
                cause_wr_data[8:5] == trap_cause_code[8:5];
    endproperty
    a_handler_select: assert property (p_handler_select) // [RULE15]
        else $error("handler select bits not inserted");

    property p_vector_low_zero;
        @(posedge clk) disable iff (!reset_n)
        trap_vector_base[14:0] == 15'h0000;
    endproperty
    a_vector_low_zero: assert property (p_vector_low_zero) // [RULE14]
        else $error("vector base low bits not zero");

    property p_return_restores;
        @(posedge clk) disable iff (!reset_n)
        return_fire |=> rest_valid &&
                        rest_word == $past(ss_rd_data) ##1
                        rest_valid == $past(return_fire);
    endproperty
    a_return_restores: assert property (p_return_restores) // [RULE6]
        else $error("return did not restore current entry");

    property p_cause_readback;
        @(posedge clk) disable iff (!reset_n)
        trap_fire ##1 !cause_wr_en ##1
            (access_fire && !preg_write &&
             preg_sel == trap_stack_pkg::REG_TRAP_CAUSE &&
             trap_level == $past(trap_level, 2) + 3'h1)
            |=> preg_done && preg_rdata[8:0] == $past(cause_wr_data, 3);
    endproperty
    a_cause_readback: assert property (p_cause_readback) // [RULE9]
        else $error("cause entry does not hold trap code");

endmodule
`default_nettype wire

// [shared/trap_stack_pkg.sv]
`default_nettype none
package trap_stack_pkg;

    // stack geometry
    localparam int MAX_TRAP_DEPTH = 6;
    localparam int LEVEL_W        = 3;
    typedef logic [LEVEL_W-1:0] level_t;
    localparam level_t LEVEL_MAX  = 3'h6;
    localparam level_t LEVEL_ZERO = 3'h0;
    localparam level_t LEVEL_ONE  = 3'h1;

    // saved-state entry layout
    localparam int SS_W        = 43;
    localparam int SS_GL_LO    = 40;
    localparam int SS_GL_W     = 3;
    localparam int SS_CCR_LO   = 32;
    localparam int SS_CCR_W    = 8;
    localparam int SS_ASI_LO   = 24;
    localparam int SS_ASI_W    = 8;
    localparam int SS_PCW_LO   = 8;
    localparam int SS_PCW_W    = 13;
    localparam int SS_CWP_LO   = 0;
    localparam int SS_CWP_W    = 5;
    localparam logic [SS_W-1:0] SS_WRITE_MASK = 43'h7ff_ff1f_ff1f;

    // trap-cause entry
    localparam int CAUSE_W     = 9;
    localparam logic [CAUSE_W-1:0] CAUSE_POR = 9'h001;
    localparam int CAUSE_SEL_LO = 2;
    localparam int SEL_W        = 3;

    // vector base
    localparam int VB_W        = 64;
    localparam logic [VB_W-1:0] VB_WRITE_MASK = 64'hffff_ffff_ffff_8000;
    localparam logic [VB_W-1:0] VB_RESET      = 64'h0000_0000_0000_0000;

    // privileged register selector
    typedef enum logic [1:0] {
        REG_SAVED_STATE,
        REG_TRAP_CAUSE,
        REG_VECTOR_BASE
    } priv_reg_e;

endpackage
`default_nettype wire

// [sim/tb_trap_level_state_stack.sv]
`default_nettype none
module tb_trap_level_state_stack;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, reset_n, trap_take, trap_spill_fill, return_take, rest_valid;
    logic preg_valid, preg_write, preg_done, bad_opcode, load;
    trap_stack_pkg::level_t trap_level, load_level;
    trap_stack_pkg::priv_reg_e preg_sel;
    logic [8:0]  trap_cause_code;
    logic [2:0]  window_handler_select, bank_select_level, rest_gl;
    logic [7:0]  cur_ccr, cur_asi, rest_ccr, rest_asi;
    logic [12:0] cur_pcw, rest_pcw;
    logic [4:0]  cur_cwp, rest_cwp;
    logic [63:0] preg_wdata, preg_rdata, trap_vector_base;
    int          errors, comparisons, lvl;

    trap_seq_model partner (.clk(clk), .reset_n(reset_n),
        .trap_take(trap_take), .return_take(return_take), .load(load),
        .load_level(load_level), .trap_level(trap_level));

    trap_level_state_stack DUT (.clk(clk), .reset_n(reset_n),
        .trap_level(trap_level), .trap_take(trap_take),
        .trap_cause_code(trap_cause_code), .trap_spill_fill(trap_spill_fill),
        .window_handler_select(window_handler_select),
        .bank_select_level(bank_select_level), .cur_ccr(cur_ccr),
        .cur_asi(cur_asi), .cur_pcw(cur_pcw), .cur_cwp(cur_cwp),
        .return_take(return_take), .rest_valid(rest_valid),
        .rest_gl(rest_gl), .rest_ccr(rest_ccr), .rest_asi(rest_asi),
        .rest_pcw(rest_pcw), .rest_cwp(rest_cwp), .preg_valid(preg_valid),
        .preg_write(preg_write), .preg_sel(preg_sel),
        .preg_wdata(preg_wdata), .preg_done(preg_done),
        .preg_rdata(preg_rdata), .bad_opcode(bad_opcode),
        .trap_vector_base(trap_vector_base));

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [63:0] pack(input logic [2:0] gl,
        input logic [7:0] ccr, input logic [7:0] asi, input logic [12:0] pcw,
        input logic [4:0] cwp);
        return {21'h0, gl, ccr, asi, 3'h0, pcw, 3'h0, cwp};
    endfunction

    // field values derived from a small index so every entry differs
    function automatic logic [63:0] entry_word(input logic [3:0] k);
        return pack(k[2:0], 8'hc0 | k, 8'h30 + k, 13'h1555 ^ k, 5'h18 - k);
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic set_level(input trap_stack_pkg::level_t value);
        @(posedge clk);
        #1;
        load = 1'b1;
        load_level = value;
        @(posedge clk);
        #1;
        load = 1'b0;
    endtask

    task automatic trap(input logic [3:0] k, input logic [8:0] code,
        input logic spill, input logic [2:0] sel);
        @(posedge clk);
        #1;
        trap_take = 1'b1;
        trap_cause_code = code;
        trap_spill_fill = spill;
        window_handler_select = sel;
        bank_select_level = k[2:0];
        cur_ccr = 8'hc0 | k;
        cur_asi = 8'h30 + k;
        cur_pcw = 13'h1555 ^ k;
        cur_cwp = 5'h18 - k;
        @(posedge clk);
        #1;
        trap_take = 1'b0;
    endtask

    // a return taken at one edge shows rest_valid right after that edge
    task automatic ret(input logic exp_valid, input logic [63:0] exp_word);
        @(posedge clk);
        #1;
        return_take = 1'b1;
        @(posedge clk);
        #1;
        return_take = 1'b0;
        check(rest_valid, exp_valid);
        if (exp_valid) begin
            check(pack(rest_gl, rest_ccr, rest_asi, rest_pcw, rest_cwp),
                exp_word);
        end
    endtask

    task automatic access(input trap_stack_pkg::priv_reg_e sel,
        input logic wr, input logic [63:0] wdata, input logic exp_bad,
        input logic [63:0] exp_rdata);
        @(posedge clk);
        #1;
        preg_valid = 1'b1;
        preg_sel = sel;
        preg_write = wr;
        preg_wdata = wdata;
        @(posedge clk);
        #1;
        preg_valid = 1'b0;
        check(bad_opcode, exp_bad);
        check(preg_done, !exp_bad);
        check(preg_rdata, exp_rdata);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        check(trap_vector_base, 64'h0);
        check(rest_valid, 1'b0);
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b0, 64'h0, 1'b0,
            64'h1);
        $display("test reset done");
    endtask

    task automatic test_push_pop;
        set_level(3'h0);
        for (int i = 0; i < 6; i++) begin
            trap(i[3:0], 9'h100 + i[8:0], 1'b0, 3'h0);
        end
        // a trap at the deepest level has no entry to go to
        trap(4'h9, 9'h1ee, 1'b0, 3'h0);
        for (lvl = 6; lvl >= 1; lvl--) begin
            access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b0, 64'h0, 1'b0,
                64'h100 + lvl - 1);
            access(trap_stack_pkg::REG_SAVED_STATE, 1'b0, 64'h0, 1'b0,
                entry_word(lvl[3:0] - 4'h1));
            ret(1'b1, entry_word(lvl[3:0] - 4'h1));
        end
        ret(1'b0, 64'h0);
        $display("test push pop done");
    endtask

    task automatic test_spill_and_write;
        set_level(3'h2);
        trap(4'h7, 9'h080, 1'b1, 3'h5);
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b0, 64'h0, 1'b0,
            64'h094);
        access(trap_stack_pkg::REG_SAVED_STATE, 1'b1, '1, 1'b0,
            entry_word(4'h7));
        access(trap_stack_pkg::REG_SAVED_STATE, 1'b0, 64'h0, 1'b0,
            64'h7ff_ff1f_ff1f);
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b1, '1, 1'b0,
            64'h094);
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b0, 64'h0, 1'b0,
            64'h1ff);
        access(trap_stack_pkg::REG_VECTOR_BASE, 1'b1, '1, 1'b0,
            64'h0);
        access(trap_stack_pkg::REG_VECTOR_BASE, 1'b0, 64'h0, 1'b0,
            64'hffff_ffff_ffff_8000);
        check(trap_vector_base, 64'hffff_ffff_ffff_8000);
        $display("test spill and write done");
    endtask

    task automatic test_level_zero;
        // entry 1 is written afresh so nothing relies on a stale entry
        set_level(3'h0);
        trap(4'h2, 9'h0a5, 1'b0, 3'h0);
        access(trap_stack_pkg::REG_SAVED_STATE, 1'b1, 64'h234_561f_0a1b,
            1'b0, entry_word(4'h2));
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b1, 64'h0aa, 1'b0,
            64'h0a5);
        set_level(3'h0);
        access(trap_stack_pkg::REG_SAVED_STATE, 1'b1, 64'h0, 1'b1,
            64'h0);
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b1, 64'h0, 1'b1,
            64'h0);
        access(trap_stack_pkg::REG_SAVED_STATE, 1'b0, 64'h0, 1'b1,
            64'h0);
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b0, 64'h0, 1'b1,
            64'h0);
        set_level(3'h7);
        access(trap_stack_pkg::REG_SAVED_STATE, 1'b0, 64'h0, 1'b1,
            64'h0);
        set_level(3'h1);
        access(trap_stack_pkg::REG_SAVED_STATE, 1'b0, 64'h0, 1'b0,
            64'h234_561f_0a1b);
        access(trap_stack_pkg::REG_TRAP_CAUSE, 1'b0, 64'h0, 1'b0,
            64'h0aa);
        $display("test level zero done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        trap_take = 1'b0;
        trap_cause_code = 9'h000;
        trap_spill_fill = 1'b0;
        window_handler_select = 3'h0;
        bank_select_level = 3'h0;
        cur_ccr = 8'h00;
        cur_asi = 8'h00;
        cur_pcw = 13'h0000;
        cur_cwp = 5'h00;
        return_take = 1'b0;
        preg_valid = 1'b0;
        preg_write = 1'b0;
        preg_sel = trap_stack_pkg::REG_SAVED_STATE;
        preg_wdata = 64'h0;
        load = 1'b0;
        load_level = 3'h0;
        errors = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        test_reset();
        test_push_pop();
        test_spill_and_write();
        test_level_zero();
        stop_test();
    end

    // the tests need about a hundred and ten cycles; this is well beyond that
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire

// [sim/trap_seq_model.sv]
`default_nettype none
module trap_seq_model (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // events seen by the block
    input  wire logic                    trap_take,
    input  wire logic                    return_take,
    // direct level load, stands in for a level register write
    input  wire logic                    load,
    input  wire trap_stack_pkg::level_t  load_level,
    // current level handed to the block
    output var trap_stack_pkg::level_t   trap_level
);
    timeunit 1ns;
    timeprecision 1ps;

    trap_stack_pkg::level_t next_trap_level;

    always_comb begin
        next_trap_level = trap_level;
        if (load) begin
            next_trap_level = load_level;
        end else if (trap_take && trap_level < trap_stack_pkg::LEVEL_MAX) begin
            next_trap_level = trap_level + 3'h1;
        end else if (return_take &&
                     trap_level != trap_stack_pkg::LEVEL_ZERO) begin
            next_trap_level = trap_level - 3'h1;
        end
    end

    // power-on reset is itself a trap, so the level starts at the deepest one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trap_level <= trap_stack_pkg::LEVEL_MAX;
        end else begin
            trap_level <= next_trap_level;
        end
    end
endmodule
`default_nettype wire
